// ---- design/dodt_pkg.sv ----
// dodt_pkg: constants, types and register map of the termination controller.
// assumes: shared by dodt_ctrl, dodt_monitor, dodt_host and the testbench; no logic lives here.
`default_nettype none
package dodt_pkg;
   // register byte offsets on the ahb-lite bus
   localparam logic [7:0] MR_ONE_OFS = 8'h00;
   localparam logic [7:0] MR_TWO_OFS = 8'h04;
   localparam logic [7:0] MR_FIVE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;

   // mode_register_one fields
   localparam int DLL_EN_BIT = 0;
   localparam int AL_LSB = 1;
   // mode_register_two fields
   localparam int CWL_LSB = 0;
   localparam int RTT_WR_LSB = 5;
   localparam int CRC_BIT = 8;
   // mode_register_five fields
   localparam int BUFDIS_BIT = 0;
   localparam int PL_LSB = 1;
   localparam int PRE2T_BIT = 4;
   // status fields
   localparam int ST_WR_BIT = 0;
   localparam int ST_NOM_BIT = 1;
   localparam int ST_ASYNC_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_PD_BIT = 4;

   // reset values
   localparam logic [31:0] MR_ONE_RST = 32'h0000_0001;
   localparam logic [31:0] MR_TWO_RST = 32'h0000_0009;
   localparam logic [31:0] MR_FIVE_RST = 32'h0000_0000;

   // write-switch latency: wl minus this
   localparam logic [6:0] CNW_SUB_1T = 7'h02;
   localparam logic [6:0] CNW_SUB_2T = 7'h03;
   // end offsets after the switch latency
   localparam logic [6:0] OFF_BC4_1T = 7'h04;
   localparam logic [6:0] OFF_BL8_1T = 7'h06;
   localparam logic [6:0] OFF_BC4_1T_CRC = 7'h07;
   localparam logic [6:0] OFF_BL8_1T_CRC = 7'h07;
   localparam logic [6:0] OFF_BC4_2T = 7'h05;
   localparam logic [6:0] OFF_BL8_2T = 7'h07;
   localparam logic [6:0] OFF_BC4_2T_CRC = 7'h08;
   localparam logic [6:0] OFF_BL8_2T_CRC = 7'h08;
   localparam int HIST_W = 64;

   // asynchronous mode delays, in tenths of a ns, and ref clock period
   localparam int ASYNC_MIN_DNS = 10;
   localparam int ASYNC_MAX_DNS = 90;
   localparam int REF_PERIOD_DNS = 100;
   localparam int ASYNC_MIN_RAW = (ASYNC_MIN_DNS + REF_PERIOD_DNS - 1) / REF_PERIOD_DNS;
   localparam int ASYNC_MAX_RAW = ASYNC_MAX_DNS / REF_PERIOD_DNS;
   localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
   localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
   localparam logic [3:0] ASYNC_CYC = 4'(ASYNC_MAX_CYC);

   // termination selection seen at the data pins
   typedef enum logic [1:0] {
      TERM_PARK = 2'b00,
      TERM_NOM = 2'b01,
      TERM_WR = 2'b10
   } dodt_term_e;

   // configuration handed to the link domain
   typedef struct packed {
      logic dll_en;
      logic [5:0] al;
      logic [4:0] cwl;
      logic [2:0] rtt_wr;
      logic crc;
      logic bufdis;
      logic [2:0] pl;
      logic pre2t;
   } dodt_cfg_s;

   // command strobes from the controller on the link clock
   typedef struct packed {
      logic odt;
      logic cke;
      logic wr;
      logic bc4;
   } dodt_cmd_s;
endpackage : dodt_pkg
`default_nettype wire

// ---- design/dodt_sync.sv ----
// dodt_sync: two-flop synchroniser for a group of independent levels.
// assumes: each bit is a level on its own; no bus coherence is implied.
`timescale 1ns/100ps
`default_nettype none
module dodt_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule : dodt_sync
`default_nettype wire

// ---- design/dodt_ctrl.sv ----
// dodt_ctrl: on-die termination control, dynamic, asynchronous and power-down.
// assumes: ahb-lite master on ref_clk_i; controller drives odt, cke, writes on ck_i.
//
// How it works
// - write termination starts wl-2 cycles after a write, or wl-3 with two-cycle preamble.
// - with one-cycle preamble and crc off it ends 4 (bc4) or 6 (bl8) cycles after that start.
// - bc4 ends +7 (1t crc), +5 (2t no crc) or +8 (2t crc) after the start.
// - bl8 ends +7 (1t crc), +7 (2t no crc) or +8 (2t crc) after the start.
// - termination runs asynchronously whenever the dll enable bit is zero.
// - in asynchronous mode nominal termination follows the pin with no latency added.
// - asynchronous turn-on begins after 1.0 ns and completes by 9.0 ns; here it comes one 10 ns ref cycle after the sync flops.
// - asynchronous turn-off begins after 1.0 ns and reaches park by 9.0 ns; here it comes one 10 ns ref cycle after the sync flops.
// - with buffer disable set, no nominal termination is given in power-down.
// - odt samples after cke low, and the wl-1 cycles before it, may be dropped.
// - dynamic termination is on when the write-termination field is non-zero.
// - outside write windows odt selects nominal after its latency, else park.
// - dynamic write termination is never used with the dll off.
// - write latency is cas write latency plus additive plus parity latency.
`timescale 1ns/100ps
`default_nettype none
module dodt_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // link side, on the controller's command clock
   input wire logic ck_i,
   input wire dodt_pkg::dodt_cmd_s cmd_i,
   output dodt_pkg::dodt_term_e term_sel_o,
   // asynchronous-mode nominal termination, ref clock domain
   output logic async_nom_o
);
   import dodt_pkg::*;

   // ---------------- register file, ref clock ----------------
   logic [31:0] mr_one_reg;
   logic [31:0] mr_two_reg;
   logic [31:0] mr_five_reg;
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic cfg_tgl_reg;
   logic ack_s;
   logic busy;
   // synced link flags: [2] power-down, [1] nominal, [0] write termination
   logic [2:0] lk_s;
   logic odt_s;
   logic cke_s;
   logic [3:0] acnt_reg;
   dodt_cfg_s cfg;
   logic [2:0] wsel;
   logic [2:0] rsel;
   // link flags, declared here as the ref-side synchroniser reads them
   logic lk_ack_reg;
   logic lk_pd_reg;
   logic lk_wr_reg;
   logic lk_nom_reg;

   // an address phase is taken only when the bus is ready
   function automatic logic take(input logic sel, input logic [1:0] tr, input logic rdy);
      take = sel && tr[1] && rdy;
   endfunction : take

   // one-hot select of the mode register an offset names, zero if unmapped
   function automatic logic [2:0] mr_sel(input logic [7:0] a);
      logic [2:0] s;
      s = 3'b000;
      if (a == MR_ONE_OFS) begin
         s = 3'b001;
      end else if (a == MR_TWO_OFS) begin
         s = 3'b010;
      end else if (a == MR_FIVE_OFS) begin
         s = 3'b100;
      end
      mr_sel = s;
   endfunction : mr_sel

   // one decode serves both the write and the read data paths
   assign wsel = mr_sel(addr_reg);
   assign rsel = mr_sel(haddr_i[7:0]);

   // zero wait states, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   // busy while the link has not yet taken the last configuration
   assign busy = cfg_tgl_reg ^ ack_s;

   // address phase capture
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else if (hready_i) begin
         wr_pend_reg <= take(hsel_i, htrans_i, hready_i) && hwrite_i;
         addr_reg <= haddr_i[7:0];
      end
   end

   // data phase writes; refused while busy so the link snapshot stays stable
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mr_one_reg <= MR_ONE_RST;
         mr_two_reg <= MR_TWO_RST;
         mr_five_reg <= MR_FIVE_RST;
         cfg_tgl_reg <= 1'b0;
      end else if (wr_pend_reg && !busy) begin
         // a refused write is dropped silently; software polls busy first
         if (wsel[0]) begin
            mr_one_reg <= hwdata_i;
            cfg_tgl_reg <= ~cfg_tgl_reg;
         end else if (wsel[1]) begin
            mr_two_reg <= hwdata_i;
            cfg_tgl_reg <= ~cfg_tgl_reg;
         end else if (wsel[2]) begin
            mr_five_reg <= hwdata_i;
            cfg_tgl_reg <= ~cfg_tgl_reg;
         end
      end
   end

   // read data loaded at the address edge, stands in the data phase
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (take(hsel_i, htrans_i, hready_i) && !hwrite_i) begin
         if (rsel[0]) begin
            hrdata_o <= {25'h000_0000, mr_one_reg[6:0]};
         end else if (rsel[1]) begin
            hrdata_o <= {23'h00_0000, mr_two_reg[8:0]};
         end else if (rsel[2]) begin
            hrdata_o <= {27'h000_0000, mr_five_reg[4:0]};
         end else if (haddr_i[7:0] == STATUS_OFS) begin
            hrdata_o <= {27'h000_0000, lk_s[2], busy, ~cfg.dll_en, lk_s[1], lk_s[0] | lk_s[1]};
         end else begin
            // unmapped offsets read as zero
            hrdata_o <= 32'h0000_0000;
         end
      end
   end

   // field unpacking into the carrier
   always_comb begin
      cfg.dll_en = mr_one_reg[DLL_EN_BIT];
      cfg.al = mr_one_reg[AL_LSB +: 6];
      cfg.cwl = mr_two_reg[CWL_LSB +: 5];
      cfg.rtt_wr = mr_two_reg[RTT_WR_LSB +: 3];
      cfg.crc = mr_two_reg[CRC_BIT];
      cfg.bufdis = mr_five_reg[BUFDIS_BIT];
      cfg.pl = mr_five_reg[PL_LSB +: 3];
      cfg.pre2t = mr_five_reg[PRE2T_BIT];
   end

   // pins and link flags into the ref domain; write and nominal flags cross
   // apart and are merged after the flops, so a window end cannot glitch
   dodt_sync #(.W(6)) u_ref_sync (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i({cmd_i.odt, cmd_i.cke, lk_ack_reg, lk_pd_reg, lk_nom_reg, lk_wr_reg}),
      .q_o({odt_s, cke_s, ack_s, lk_s})
   );

   // ---------------- asynchronous mode, ref clock ----------------
   // change is held off one whole 10 ns cycle after capture, beyond the 1.0..9.0 ns range
   // limitation: the two sync flops come on top, so that delay counts from capture,
   // not from the pin itself
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         async_nom_o <= 1'b0;
         acnt_reg <= 4'h0;
      end else if (cfg.dll_en) begin
         async_nom_o <= 1'b0;
         acnt_reg <= 4'h0;
      end else if ((odt_s && !(cfg.bufdis && !cke_s)) != async_nom_o) begin
         if (acnt_reg + 4'h1 >= ASYNC_CYC) begin
            async_nom_o <= ~async_nom_o;
            acnt_reg <= 4'h0;
         end else begin
            acnt_reg <= acnt_reg + 4'h1;
         end
      end else begin
         acnt_reg <= 4'h0;
      end
   end

   // ---------------- link domain, ck_i ----------------
   logic lrst;
   logic tgl_s;
   logic tgl_d_reg;
   logic odt_smp;
   dodt_cfg_s lcfg_reg;
   logic [HIST_W-1:0] bc4_hist_reg;
   logic [HIST_W-1:0] bl8_hist_reg;
   logic [HIST_W-1:0] odt_hist_reg;
   logic [HIST_W-1:0] bc4_next;
   logic [HIST_W-1:0] bl8_next;
   logic [HIST_W-1:0] odt_next;
   logic [6:0] wl;
   logic [6:0] cnw;
   logic dyn_en;
   logic win;
   logic nom_req;
   logic block_nom;

   // reset and config toggle into the link clock
   dodt_sync #(.W(2)) u_link_sync (
      .clk_i(ck_i),
      .rst_i(1'b0),
      .d_i({rst_i, cfg_tgl_reg}),
      .q_o({lrst, tgl_s})
   );

   // end offset after the switch latency, by burst, preamble and crc
   function automatic logic [6:0] off_of(input logic bc4, input logic p2, input logic crc);
      logic [6:0] r;
      r = OFF_BL8_1T;
      if (!p2 && !crc) begin
         r = bc4 ? OFF_BC4_1T : OFF_BL8_1T;
      end else if (bc4) begin
         r = !p2 ? OFF_BC4_1T_CRC : (crc ? OFF_BC4_2T_CRC : OFF_BC4_2T);
      end else begin
         r = !p2 ? OFF_BL8_1T_CRC : (crc ? OFF_BL8_2T_CRC : OFF_BL8_2T);
      end
      off_of = r;
   endfunction : off_of

   // true if any write k cycles back lies in [lo, hi)
   // histories span HIST_W edges, so wl + 8 must stay below that
   function automatic logic in_win(input logic [HIST_W-1:0] h, input logic [6:0] lo,
                                   input logic [6:0] hi);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < HIST_W; i++) begin
         if (h[i] && 7'(i) >= lo && 7'(i) < hi) begin
            hit = 1'b1;
         end
      end
      in_win = hit;
   endfunction : in_win

   // snapshot of the configuration on each handshake toggle
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         tgl_d_reg <= 1'b0;
         lk_ack_reg <= 1'b0;
         lcfg_reg <= '0;
      end else begin
         tgl_d_reg <= tgl_s;
         if (tgl_s != tgl_d_reg) begin
            lcfg_reg <= cfg; // held still by the busy refusal
            lk_ack_reg <= tgl_s;
         end
      end
   end

   // latencies; a wl below the subtrahend clamps to zero rather than wrapping
   always_comb begin
      wl = 7'(lcfg_reg.cwl) + 7'(lcfg_reg.al) + 7'(lcfg_reg.pl);
      if (lcfg_reg.pre2t) begin
         cnw = (wl > CNW_SUB_2T) ? wl - CNW_SUB_2T : 7'h00;
      end else begin
         cnw = (wl > CNW_SUB_1T) ? wl - CNW_SUB_1T : 7'h00;
      end
      dyn_en = (lcfg_reg.rtt_wr != 3'b000) && lcfg_reg.dll_en;
   end

   // buffer disable with cke low: floated odt is never looked at
   assign block_nom = lcfg_reg.bufdis && !cmd_i.cke;

   // samples taken with the buffer off are stored low, so a floating pin in
   // power-down never comes back as a late nominal request after exit
   assign odt_smp = cmd_i.odt && !block_nom;

   // histories with this edge's sample in bit 0
   assign bc4_next = {bc4_hist_reg[HIST_W-2:0], cmd_i.wr & cmd_i.bc4};
   assign bl8_next = {bl8_hist_reg[HIST_W-2:0], cmd_i.wr & ~cmd_i.bc4};
   assign odt_next = {odt_hist_reg[HIST_W-2:0], odt_smp};

   always_ff @(posedge ck_i) begin
      if (lrst) begin
         bc4_hist_reg <= '0;
         bl8_hist_reg <= '0;
         odt_hist_reg <= '0;
      end else begin
         bc4_hist_reg <= bc4_next;
         bl8_hist_reg <= bl8_next;
         odt_hist_reg <= odt_next;
      end
   end

   // window and nominal request for this edge
   always_comb begin
      win = in_win(bc4_next, cnw, cnw + off_of(1'b1, lcfg_reg.pre2t, lcfg_reg.crc))
         || in_win(bl8_next, cnw, cnw + off_of(1'b0, lcfg_reg.pre2t, lcfg_reg.crc));
      nom_req = odt_next[cnw[5:0]];
   end

   // termination selection and status flags
   // priority: dll off, then write window, then nominal, else park
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         term_sel_o <= TERM_PARK;
         lk_wr_reg <= 1'b0;
         lk_nom_reg <= 1'b0;
         lk_pd_reg <= 1'b0;
      end else begin
         lk_pd_reg <= !cmd_i.cke;
         if (!lcfg_reg.dll_en) begin
            // asynchronous path owns nominal termination here
            term_sel_o <= TERM_PARK;
            lk_wr_reg <= 1'b0;
            lk_nom_reg <= 1'b0;
         end else if (dyn_en && win) begin
            term_sel_o <= TERM_WR;
            lk_wr_reg <= 1'b1;
            lk_nom_reg <= 1'b0;
         end else if (nom_req && !block_nom) begin
            // after exit odt is held low and, with buffer disable set, power-down samples
            // were stored low, so no stale request shows
            term_sel_o <= TERM_NOM;
            lk_wr_reg <= 1'b0;
            lk_nom_reg <= 1'b1;
         end else begin
            term_sel_o <= TERM_PARK;
            lk_wr_reg <= 1'b0;
            lk_nom_reg <= 1'b0;
         end
      end
   end
endmodule : dodt_ctrl
`default_nettype wire

// ---- verif/dodt_monitor.sv ----
// dodt_monitor: port-level checks of the termination controller.
// assumes: bound to dodt_ctrl; helper ages count command clock edges.
`timescale 1ns/100ps
`default_nettype none
module dodt_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ck_i,
   input wire dodt_pkg::dodt_cmd_s cmd_i,
   input wire dodt_pkg::dodt_term_e term_sel_o,
   input wire logic async_nom_o
);
   import dodt_pkg::*;
   logic [6:0] since_wr_reg;
   logic [6:0] odt_lo_reg;
   // saturating ages of the last write and of the last odt high sample
   always_ff @(posedge ck_i) begin
      if (rst_i) begin
         since_wr_reg <= 7'h7f;
         odt_lo_reg <= 7'h00;
      end else begin
         since_wr_reg <= cmd_i.wr ? 7'h00 : since_wr_reg + {6'h00, since_wr_reg != 7'h7f};
         odt_lo_reg <= cmd_i.odt ? 7'h00 : odt_lo_reg + {6'h00, odt_lo_reg != 7'h7f};
      end
   end
   // first edge of a write-termination window
   sequence wr_start_s;
      $rose(term_sel_o == TERM_WR);
   endsequence
   // odt held low long enough to flush the sync pipe
   sequence odt_quiet_s;
      (!cmd_i.odt) [*8];
   endsequence
   wr_after_write_a: assert property (@(posedge ck_i) disable iff (rst_i)
      wr_start_s |-> since_wr_reg inside {[7'd6:7'd62]})
      else $error("write termination without a matching write");
   wr_min_hold_a: assert property (@(posedge ck_i) disable iff (rst_i)
      wr_start_s |-> (term_sel_o == TERM_WR) [*4])
      else $error("write termination shorter than four cycles");
   wr_end_bound_a: assert property (@(posedge ck_i) disable iff (rst_i)
      wr_start_s |-> ##[4:8] (term_sel_o != TERM_WR))
      else $error("write termination longer than eight cycles");
   park_idle_a: assert property (@(posedge ck_i) disable iff (rst_i)
      (since_wr_reg >= 7'd64 && odt_lo_reg >= 7'd64) |-> term_sel_o == TERM_PARK)
      else $error("idle link not parked");
   nom_needs_odt_a: assert property (@(posedge ck_i) disable iff (rst_i)
      odt_lo_reg >= 7'd64 |-> term_sel_o != TERM_NOM)
      else $error("nominal termination without odt");
   async_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      odt_quiet_s |-> !async_nom_o)
      else $error("asynchronous nominal stays on after odt low");
   async_excl_a: assert property (@(posedge ck_i) disable iff (rst_i)
      async_nom_o |-> term_sel_o != TERM_WR)
      else $error("write termination while asynchronous");
   sel_excl_a: assert property (@(posedge ck_i) disable iff (rst_i)
      term_sel_o == TERM_NOM |-> !async_nom_o)
      else $error("both nominal paths active");
endmodule : dodt_monitor
`default_nettype wire

// ---- verif/dodt_host.sv ----
// dodt_host: memory controller model driving odt, cke and write strobes.
// assumes: ck_i is the free-running command clock made by the bench.
`timescale 1ns/100ps
`default_nettype none
module dodt_host #(
   parameter int PD_ENTRY_CYC = 3, // entry buffer delay, plain default
   parameter int PD_EXIT_CYC = 4 // exit time, plain default
) (
   input wire logic ck_i,
   output var dodt_pkg::dodt_cmd_s cmd_o
);
   import dodt_pkg::*;
   logic float_reg;
   // idle: cke high, odt low, no write
   initial begin
      cmd_o = 4'b0100;
      float_reg = 1'b0;
   end
   // a floating odt pin is shown as a level that changes every cycle
   always @(posedge ck_i) begin
      if (float_reg) begin
         cmd_o.odt <= ~cmd_o.odt;
      end
   end
   task automatic write_cmd(input logic bc4);
      @(posedge ck_i);
      cmd_o.wr <= 1'b1;
      cmd_o.bc4 <= bc4;
      @(posedge ck_i);
      cmd_o.wr <= 1'b0;
      cmd_o.bc4 <= ~bc4; // no stale qualifier after release
   endtask : write_cmd
   // returns at the edge that samples the new level
   task automatic set_odt(input logic v);
      @(posedge ck_i);
      cmd_o.odt <= v;
      @(posedge ck_i);
   endtask : set_odt
   task automatic pd_enter();
      @(posedge ck_i);
      cmd_o.cke <= 1'b0;
      repeat (PD_ENTRY_CYC) @(posedge ck_i);
      float_reg <= 1'b1;
   endtask : pd_enter
   // float stops one edge early so odt has a single driver per edge
   task automatic pd_exit();
      @(posedge ck_i);
      float_reg <= 1'b0;
      @(posedge ck_i);
      cmd_o.cke <= 1'b1;
      cmd_o.odt <= 1'b0;
      repeat (PD_EXIT_CYC) @(posedge ck_i);
   endtask : pd_exit
endmodule : dodt_host
`default_nettype wire

// ---- verif/testbench.sv ----
// testbench: drives dodt_ctrl over ahb-lite and through the host model.
// assumes: ref clock 100 MHz, command clock 15 ns, monitor bound below.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
   import dodt_pkg::*;
   logic ref_clk_i, ck_i, rst_i, hsel, hwrite, hready, anom;
   logic [1:0] htrans;
   logic [2:0] c, hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   dodt_cmd_s cmd;
   dodt_term_e term;
   int err_count, comparisons, s, l, k;
   int offt[8] = '{6, 4, 7, 7, 7, 5, 8, 8};
   // two unrelated clocks
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      ck_i = 1'b0;
      #3;
      forever #7.5 ck_i = ~ck_i;
   end
   dodt_ctrl i_dodt_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(), .ck_i(ck_i), .cmd_i(cmd), .term_sel_o(term), .async_nom_o(anom));
   dodt_host i_dodt_host (.ck_i(ck_i), .cmd_o(cmd));
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      haddr <= {24'h00_0000, a};
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // a write is refused while the crossing is busy, so poll after each
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
      k = 0;
      do begin
         ahb(1'b0, STATUS_OFS, 32'h0000_0000);
         k++;
      end while (rd[ST_BUSY_BIT] !== 1'b0 && k < 40);
      `CHK(rd[ST_BUSY_BIT], 1'b0)
   endtask : wr_reg
   task automatic cfg(input logic [31:0] m1, m2, m5);
      wr_reg(MR_ONE_OFS, m1);
      wr_reg(MR_TWO_OFS, m2);
      wr_reg(MR_FIVE_OFS, m5);
   endtask : cfg
   // first edge and number of edges showing termination v
   task automatic scan(input dodt_term_e v);
      s = -1;
      l = 0;
      for (int i = 1; i < 40; i++) begin
         @(posedge ck_i);
         #1;
         if (term === v) begin
            if (s < 0) s = i;
            l++;
         end
      end
   endtask : scan
   task automatic final_report();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // hang guard, far beyond the few thousand cycles of the tests
   initial begin
      #300000;
      err_count++;
      final_report();
   end
   initial begin
      {rst_i, hsel, htrans, hwrite, hsize, haddr, hwdata} = {1'b1, 71'h0};
      {err_count, comparisons} = 0;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge ck_i);
      ahb(1'b0, MR_ONE_OFS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      ahb(1'b0, MR_TWO_OFS, 32'h0000_0000);
      `CHK(rd, 32'h0000_0009)
      ahb(1'b0, 8'h10, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      // every preamble, crc and burst case, then added and parity latency
      for (int i = 0; i < 9; i++) begin
         c = (i == 8) ? 3'b000 : i[2:0];
         cfg((i == 8) ? 32'h0000_0005 : 32'h0000_0001, 32'h0000_0029 | {23'h00_0000, c[1],
            8'h00}, (i == 8) ? 32'h0000_0002 : {27'h000_0000, c[2], 4'h0});
         i_dodt_host.write_cmd(c[0]);
         scan(TERM_WR);
         `CHK(s, ((i == 8) ? 12 : 9) - (c[2] ? 3 : 2))
         `CHK(l, offt[c])
         `CHK(term, TERM_PARK)
      end
      // nominal follows odt; a window inside it returns to nominal
      cfg(32'h0000_0001, 32'h0000_0029, 32'h0000_0000);
      i_dodt_host.set_odt(1'b1);
      scan(TERM_NOM);
      `CHK(s, 7)
      ahb(1'b0, STATUS_OFS, 32'h0000_0000);
      `CHK(rd[1:0], 2'b11)
      i_dodt_host.write_cmd(1'b0);
      scan(TERM_WR);
      `CHK(l, 6)
      `CHK(term, TERM_NOM)
      i_dodt_host.set_odt(1'b0);
      scan(TERM_NOM);
      `CHK(l, 6)
      cfg(32'h0000_0001, 32'h0000_0009, 32'h0000_0000);
      i_dodt_host.write_cmd(1'b0);
      scan(TERM_WR);
      `CHK(l, 0)
      `CHK(term, TERM_PARK)
      // power-down with buffer disable: toggling odt gives no nominal
      cfg(32'h0000_0001, 32'h0000_0029, 32'h0000_0001);
      i_dodt_host.pd_enter();
      scan(TERM_NOM);
      `CHK(l, 0)
      i_dodt_host.pd_exit();
      scan(TERM_NOM);
      `CHK(l, 0)
      // dll off: asynchronous nominal, no write termination
      cfg(32'h0000_0000, 32'h0000_0029, 32'h0000_0000);
      ahb(1'b0, STATUS_OFS, 32'h0000_0000);
      `CHK(rd[ST_ASYNC_BIT], 1'b1)
      i_dodt_host.set_odt(1'b1);
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK(anom, 1'b1)
      i_dodt_host.write_cmd(1'b0);
      scan(TERM_WR);
      `CHK(l, 0)
      `CHK(term, TERM_PARK)
      i_dodt_host.set_odt(1'b0);
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK(anom, 1'b0)
      cfg(32'h0000_0000, 32'h0000_0009, 32'h0000_0001);
      i_dodt_host.set_odt(1'b1);
      i_dodt_host.pd_enter();
      repeat (20) @(posedge ref_clk_i);
      #1;
      `CHK(anom, 1'b0)
      ahb(1'b0, STATUS_OFS, 32'h0000_0000);
      `CHK(rd[ST_PD_BIT], 1'b1)
      i_dodt_host.pd_exit();
      i_dodt_host.set_odt(1'b1);
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK(anom, 1'b1)
      final_report();
   end
endmodule : testbench
bind dodt_ctrl dodt_monitor i_dodt_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .ck_i(ck_i), .cmd_i(cmd_i), .term_sel_o(term_sel_o), .async_nom_o(async_nom_o));
`default_nettype wire
